// *** pio_top.sv ***
// Four parallel ports behind an AHB-Lite slave.
// Assumes one master, word transfers only, pins asynchronous to hclk.
`timescale 1ns/100ps
module pio_top (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Port zero pins
	input  wire logic [7:0]  port_zero_in,
	output logic      [7:0]  port_zero_out,
	output logic      [7:0]  port_zero_oe,
	// Port one pins
	input  wire logic [7:0]  port_one_in,
	output logic      [7:0]  port_one_out,
	output logic      [7:0]  port_one_oe,
	// Port two pins
	input  wire logic [2:0]  port_two_in,
	output logic      [2:0]  port_two_out,
	output logic      [2:0]  port_two_oe,
	// Port three pins
	input  wire logic [7:0]  port_three_in,
	output logic      [7:0]  port_three_out,
	output logic      [7:0]  port_three_oe,
	// System mode
	input  wire logic        dual_clock_mode,
	// To interrupt and converter logic
	output logic             ext_irq_zero_input,
	output logic             ext_irq_five_fall,
	output logic      [7:0]  analog_channel_onehot,
	output logic             analog_enable
);
	typedef struct packed {
		logic [7:0]  p0_lat;
		logic [7:0]  p1_lat;
		logic [2:0]  p2_lat;
		logic [7:0]  p3_lat;
		logic [7:0]  p1_dir;
		logic [7:0]  p3_dir;
		logic [7:0]  adc_cr1;
		logic [7:0]  eint_cr;
		logic        wr_pend;
		logic [7:0]  wr_idx;
		logic [31:0] rdata;
		logic        p20_prev;
		logic        irq5_fall;
	} pio_top_s;

	pio_top_s st_r;
	pio_top_s st_nxt;

	pio_sync_if pins_if ();

	logic [7:0] p0_pin;
	logic [7:0] p1_pin;
	logic [2:0] p2_pin;
	logic [7:0] p3_pin;
	logic [7:0] ana_mask;
	logic [7:0] ana_mask_nxt;
	logic [7:0] rd_idx;
	logic       take;

	// Word index of a byte address; anything outside the map decodes to none
	function automatic logic [7:0] reg_index(input logic [31:0] addr);
		logic [7:0] idx;
		idx = addr[9:2];
		if (addr[31:10] != 22'h000000 || addr[1:0] != 2'h0) begin
			idx = pio_pkg::IDX_NONE;
		end
		return idx;
	endfunction

	// One-hot analog pin, or none while the converter input is disabled
	function automatic logic [7:0] analog_mask(input logic [7:0] cr1);
		logic [7:0] m;
		m = 8'h00;
		if (!cr1[pio_pkg::ADC_DIS_BIT]) begin
			m[cr1[pio_pkg::ADC_SEL_LSB +: pio_pkg::ADC_SEL_W]] = 1'b1;
		end
		return m;
	endfunction

	// Mixed-direction read: latch where driven, live pin elsewhere
	function automatic logic [7:0] mixed_read(
		input logic [7:0] dir,
		input logic [7:0] lat,
		input logic [7:0] pin
	);
		return (dir & lat) | (~dir & pin);
	endfunction

	// Words that hold state; pin words and holes in the map take no write
	function automatic logic reg_writable(input logic [7:0] idx);
		logic ok;
		ok = 1'b0;
		unique case (idx)
			pio_pkg::IDX_P0_LAT, pio_pkg::IDX_P1_LAT, pio_pkg::IDX_P2_LAT, pio_pkg::IDX_P3_LAT,
			pio_pkg::IDX_P1_DIR, pio_pkg::IDX_P3_DIR, pio_pkg::IDX_ADC_CR1, pio_pkg::IDX_EINT_CR: begin
				ok = 1'b1;
			end
			default: begin
				ok = 1'b0;
			end
		endcase
		return ok;
	endfunction

	// State after a data-phase write of one word
	function automatic pio_top_s write_word(
		input pio_top_s    s,
		input logic [7:0]  idx,
		input logic [31:0] data
	);
		pio_top_s n;
		n = s;
		unique case (idx)
			pio_pkg::IDX_P0_LAT: begin
				n.p0_lat = data[7:0];
			end
			pio_pkg::IDX_P1_LAT: begin
				n.p1_lat = data[7:0];
			end
			pio_pkg::IDX_P2_LAT: begin
				n.p2_lat = data[2:0];
			end
			pio_pkg::IDX_P3_LAT: begin
				n.p3_lat = data[7:0];
			end
			pio_pkg::IDX_P1_DIR: begin
				n.p1_dir = data[7:0];
			end
			pio_pkg::IDX_P3_DIR: begin
				n.p3_dir = data[7:0];
			end
			pio_pkg::IDX_ADC_CR1: begin
				n.adc_cr1 = data[7:0];
			end
			pio_pkg::IDX_EINT_CR: begin
				n.eint_cr = data[7:0];
			end
			default: begin
				n.wr_pend = 1'b0;
			end
		endcase
		return n;
	endfunction

	// Read value of one word, taken from the state that the access will see
	function automatic logic [31:0] read_word(
		input logic [7:0] idx,
		input pio_top_s   s,
		input logic [7:0] p0,
		input logic [7:0] p1,
		input logic [2:0] p2,
		input logic [7:0] p3,
		input logic [7:0] amask
	);
		logic [31:0] w;
		w = 32'h00000000;
		unique case (idx)
			pio_pkg::IDX_P0_LAT: begin
				w[7:0] = s.p0_lat;
			end
			pio_pkg::IDX_P0_PIN: begin
				w[7:0] = p0;
			end
			pio_pkg::IDX_P1_LAT: begin
				w[7:0] = mixed_read(s.p1_dir, s.p1_lat, p1);
			end
			pio_pkg::IDX_P2_LAT: begin
				w[2:0] = s.p2_lat;
			end
			pio_pkg::IDX_P2_PIN: begin
				w[2:0] = p2;
			end
			pio_pkg::IDX_P3_LAT: begin
				w[7:0] = mixed_read(s.p3_dir, s.p3_lat, p3) & ~amask;
			end
			pio_pkg::IDX_P1_DIR: begin
				w[7:0] = s.p1_dir;
			end
			pio_pkg::IDX_P3_DIR: begin
				w[7:0] = s.p3_dir;
			end
			pio_pkg::IDX_ADC_CR1: begin
				w[7:0] = s.adc_cr1;
			end
			pio_pkg::IDX_EINT_CR: begin
				w[7:0] = s.eint_cr;
			end
			default: begin
				w = 32'h00000000;
			end
		endcase
		return w;
	endfunction

	assign pins_if.raw = {port_three_in, port_two_in, port_one_in, port_zero_in};

	pio_sync u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pins    (pins_if.syncer)
	);

	assign p0_pin = pins_if.sync[7:0];
	assign p1_pin = pins_if.sync[pio_pkg::P1_BASE +: 8];
	assign p2_pin = pins_if.sync[pio_pkg::P2_BASE +: 3];
	assign p3_pin = pins_if.sync[pio_pkg::P3_BASE +: 8];

	assign take   = hsel & hready & (htrans == pio_pkg::HTRANS_NONSEQ || htrans == 2'h3);
	assign rd_idx = reg_index(haddr);

	assign ana_mask     = analog_mask(st_r.adc_cr1);
	assign ana_mask_nxt = analog_mask(st_nxt.adc_cr1);

	always_comb begin
		st_nxt           = st_r;
		st_nxt.wr_pend   = 1'b0;
		st_nxt.irq5_fall = 1'b0;

		// Data phase of an earlier write; only words that hold state take it
		if (st_r.wr_pend && reg_writable(st_r.wr_idx)) begin
			st_nxt = write_word(st_nxt, st_r.wr_idx, hwdata);
		end

		if (take && hwrite) begin
			st_nxt.wr_pend = 1'b1;
			st_nxt.wr_idx  = rd_idx;
		end

		// Sample in address phase
		// Uses next-state latches so a read right after a write sees the new value
		if (take && !hwrite) begin
			st_nxt.rdata = read_word(rd_idx, st_nxt, p0_pin, p1_pin, p2_pin, p3_pin, ana_mask_nxt);
		end

		// Falling edge of port two pin zero
		// Watches the pin, so an edge we drive ourselves is caught as well
		st_nxt.p20_prev  = p2_pin[0];
		st_nxt.irq5_fall = st_r.p20_prev & ~p2_pin[0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r.p0_lat    <= pio_pkg::P0_LAT_RST;
			st_r.p1_lat    <= pio_pkg::P1_LAT_RST;
			st_r.p1_dir    <= pio_pkg::DIR_RST;
			st_r.p2_lat    <= pio_pkg::P2_LAT_RST;
			st_r.p3_lat    <= pio_pkg::P3_LAT_RST;
			st_r.p3_dir    <= pio_pkg::DIR_RST;
			st_r.adc_cr1   <= pio_pkg::ADC_CR1_RST;
			st_r.eint_cr   <= pio_pkg::EINT_CR_RST;
			st_r.wr_pend   <= 1'b0;
			st_r.wr_idx    <= pio_pkg::IDX_NONE;
			st_r.rdata     <= 32'h00000000;
			st_r.p20_prev  <= 1'b1;
			st_r.irq5_fall <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Zero wait states; every access completes with OKAY
	assign hreadyout = 1'b1;
	assign hresp     = pio_pkg::HRESP_OKAY;
	assign hrdata    = st_r.rdata;

	// Pin drive, one slice per bit so each pin's override stands on its own
	genvar b;
	generate
		for (b = 0; b < 8; b++) begin : g_port_eight
			// Port zero from latch
			// Open drain: a one in the latch releases the pin so it can be an input
			assign port_zero_out[b] = 1'b0;
			if (b == 0) begin : g_irq_pin
				assign port_zero_oe[b] = ~st_r.p0_lat[b] & ~st_r.eint_cr[pio_pkg::EINT_IRQ0_BIT];
			end else begin : g_plain_pin
				assign port_zero_oe[b] = ~st_r.p0_lat[b];
			end

			assign port_one_out[b] = st_r.p1_lat[b];
			assign port_one_oe[b]  = st_r.p1_dir[b];

			// Analog overrides direction
			// The latch is kept, so leaving analog mode restores the old drive at once
			assign port_three_out[b] = st_r.p3_lat[b];
			assign port_three_oe[b]  = st_r.p3_dir[b] & ~ana_mask[b];
		end

		for (b = 0; b < 3; b++) begin : g_port_two
			assign port_two_out[b] = 1'b0;
			if (b == 0) begin : g_edge_pin
				// Stays a port pin; its edge detector watches the pin, not the latch
				assign port_two_oe[b] = ~st_r.p2_lat[b];
			end else begin : g_crystal_pin
				// Crystal owns pins one and two while dual_clock_mode is set
				assign port_two_oe[b] = ~st_r.p2_lat[b] & ~dual_clock_mode;
			end
		end
	endgenerate

	// Active low, held high while the pin is a plain port
	assign ext_irq_zero_input    = st_r.eint_cr[pio_pkg::EINT_IRQ0_BIT] ? p0_pin[0] : 1'b1;
	assign ext_irq_five_fall     = st_r.irq5_fall;
	assign analog_channel_onehot = ana_mask;
	assign analog_enable         = ~st_r.adc_cr1[pio_pkg::ADC_DIS_BIT];
endmodule

// *** pio_pkg.sv ***
// Constants shared by the parallel port block and its pin synchroniser.
// Assumes a 50 MHz AHB-Lite clock and registers of at most a byte, one per word.
package pio_pkg;
	localparam int PIN_W = 27;
	localparam int P1_BASE = 8;
	localparam int P2_BASE = 16;
	localparam int P3_BASE = 19;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_P0_LAT  = 8'h00;
	localparam logic [7:0] IDX_P1_LAT  = 8'h01;
	localparam logic [7:0] IDX_P2_LAT  = 8'h02;
	localparam logic [7:0] IDX_P3_LAT  = 8'h03;
	localparam logic [7:0] IDX_P0_PIN  = 8'h08;
	localparam logic [7:0] IDX_P2_PIN  = 8'h0A;
	localparam logic [7:0] IDX_P1_DIR  = 8'h0D;
	localparam logic [7:0] IDX_P3_DIR  = 8'h0E;
	localparam logic [7:0] IDX_ADC_CR1 = 8'h1C;
	localparam logic [7:0] IDX_EINT_CR = 8'h37;
	localparam logic [7:0] IDX_NONE    = 8'hFF;

	// Values after reset
	localparam logic [7:0] P0_LAT_RST  = 8'hFF;
	localparam logic [7:0] P1_LAT_RST  = 8'h00;
	localparam logic [2:0] P2_LAT_RST  = 3'h7;
	localparam logic [7:0] P3_LAT_RST  = 8'h00;
	localparam logic [7:0] DIR_RST     = 8'h00;
	localparam logic [7:0] ADC_CR1_RST = 8'h10;
	localparam logic [7:0] EINT_CR_RST = 8'h00;

	// Field positions
	localparam int ADC_DIS_BIT  = 4;
	localparam int ADC_SEL_LSB  = 0;
	localparam int ADC_SEL_W    = 3;
	localparam int EINT_IRQ0_BIT = 6;

	// Bus encodings
	localparam logic [1:0] HTRANS_IDLE   = 2'h0;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic       HRESP_OKAY    = 1'b0;
endpackage

// *** pio_sync_if.sv ***
// Carrier between the port block and its pin synchroniser.
// Raw pin levels go in, levels in the hclk domain come back.
`timescale 1ns/100ps
interface pio_sync_if;
	logic [pio_pkg::PIN_W-1:0] raw;
	logic [pio_pkg::PIN_W-1:0] sync;

	modport owner (output raw, input sync);
	modport syncer (input raw, output sync);
endinterface

// *** pio_sync.sv ***
// Two-flop synchroniser for every port pin input.
// Assumes pins are asynchronous to hclk; bus logic reads only the second stage.
`timescale 1ns/100ps
module pio_sync (
	// Clock and reset
	input  wire logic  hclk,
	input  wire logic  hresetn,
	// Pin levels
	pio_sync_if.syncer pins
);
	typedef struct packed {
		logic [pio_pkg::PIN_W-1:0] s1;
		logic [pio_pkg::PIN_W-1:0] s2;
	} pio_sync_s;

	pio_sync_s st_r;
	pio_sync_s st_nxt;

	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = pins.raw;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			// Reset to the idle level of the pulled-up pins, so no false falling edge follows reset
			st_r <= '1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pins.sync = st_r.s2;
endmodule

// *** pio_assertions.sv ***
// Checker for the parallel port block, bound to pio_top.
// Assumes single word transfers from one AHB-Lite master.
`timescale 1ns/100ps
module pio_assertions (
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	// Pins and side outputs
	input wire logic [7:0]  port_zero_oe,
	input wire logic [7:0]  port_one_out,
	input wire logic [7:0]  port_one_oe,
	input wire logic [2:0]  port_two_in,
	input wire logic [2:0]  port_two_oe,
	input wire logic [7:0]  port_three_oe,
	input wire logic        dual_clock_mode,
	input wire logic        ext_irq_five_fall,
	input wire logic [7:0]  analog_channel_onehot,
	input wire logic        analog_enable
);
	logic       wr_r;
	logic [7:0] idx_r;
	// Address phase kept so the data phase can be matched to it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_r  <= 1'b0;
			idx_r <= 8'h00;
		end else begin
			wr_r  <= hsel && hready && htrans[1] && hwrite;
			idx_r <= haddr[9:2];
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence wr_to(logic [7:0] i);
		wr_r && idx_r == i;
	endsequence
	sequence pin_fall;
		$fell(port_two_in[0]) ##1 !port_two_in[0] [*2];
	endsequence
	a_zero_wait: assert property (hreadyout) else $error("slave inserted a wait");
	a_p0_latch_oe: assert property (wr_to(pio_pkg::IDX_P0_LAT) |=>
		port_zero_oe[7:1] == ~$past(hwdata[7:1])) else $error("port zero drive not from latch");
	a_p1_latch_out: assert property (wr_to(pio_pkg::IDX_P1_LAT) |=>
		port_one_out == $past(hwdata[7:0])) else $error("port one latch not written");
	a_p1_dir_oe: assert property (wr_to(pio_pkg::IDX_P1_DIR) |=>
		port_one_oe == $past(hwdata[7:0])) else $error("port one direction wrong");
	a_xtal_pins_free: assert property (dual_clock_mode |-> port_two_oe[2:1] == 2'b00)
		else $error("crystal pins driven");
	a_irq5_fall_seen: assert property (pin_fall |-> ##[0:3] ext_irq_five_fall)
		else $error("falling edge missed");
	a_irq5_one_pulse: assert property (ext_irq_five_fall |=> !ext_irq_five_fall)
		else $error("edge pulse too long");
	a_analog_pin_free: assert property (analog_enable |-> (port_three_oe & analog_channel_onehot) == 8'h00)
		else $error("analog pin driven");
	a_adc_disable_bit: assert property (wr_to(pio_pkg::IDX_ADC_CR1) |=>
		analog_enable == !$past(hwdata[4])) else $error("analog enable wrong");
	a_channel_onehot: assert property (wr_to(pio_pkg::IDX_ADC_CR1) ##0 !hwdata[4] |=>
		analog_channel_onehot == (8'h01 << $past(hwdata[2:0]))) else $error("channel select wrong");
endmodule

bind pio_top pio_assertions i_pio_assertions (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hready, .hreadyout, .port_zero_oe, .port_one_out, .port_one_oe, .port_two_in, .port_two_oe,
	.port_three_oe, .dual_clock_mode, .ext_irq_five_fall, .analog_channel_onehot, .analog_enable);

// *** pio_board.sv ***
// Board model of the port pins: pull-ups on the open-drain ports.
// Assumes the bench sets what each outside source drives.
`timescale 1ns/100ps
module pio_board (
	// Design drive
	input wire logic [7:0] oe_zero,
	input wire logic [7:0] out_one,
	input wire logic [7:0] oe_one,
	input wire logic [2:0] oe_two,
	input wire logic [7:0] out_three,
	input wire logic [7:0] oe_three,
	// Outside sources
	input wire logic [7:0] ext_zero,
	input wire logic [7:0] ext_one,
	input wire logic [2:0] ext_two,
	input wire logic [7:0] ext_three,
	// Pin levels
	output logic     [7:0] lvl_zero,
	output logic     [7:0] lvl_one,
	output logic     [2:0] lvl_two,
	output logic     [7:0] lvl_three
);
	assign lvl_zero  = ext_zero & ~oe_zero;
	assign lvl_one   = (oe_one & out_one) | (~oe_one & ext_one);
	assign lvl_two   = ext_two & ~oe_two;
	assign lvl_three = (oe_three & out_three) | (~oe_three & ext_three);
endmodule

// *** tb_top.sv ***
// Self-checking bench for the parallel port block.
// Assumes zero-wait word transfers and the board model on the pins.
`timescale 1ns/100ps
module tb_top;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, dual_clock_mode = 0;
	logic [1:0]  htrans = pio_pkg::HTRANS_IDLE;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic        hreadyout, hresp, irq0, irq5, analog_enable;
	logic [7:0]  p0i, p0o, p0e, p1i, p1o, p1e, p3i, p3o, p3e, onehot, e0 = 8'hFF, e1 = 0, e3 = 0;
	logic [2:0]  p2i, p2o, p2e, e2 = 3'h7;
	int          bad_count = 0, tests_run = 0, falls = 0, f;
	always #10 hclk = ~hclk;
	always @(posedge hclk) if (irq5 === 1'b1) falls++;
	pio_top i_pio_top (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .port_zero_in(p0i), .port_zero_out(p0o),
		.port_zero_oe(p0e), .port_one_in(p1i), .port_one_out(p1o), .port_one_oe(p1e), .port_two_in(p2i),
		.port_two_out(p2o), .port_two_oe(p2e), .port_three_in(p3i), .port_three_out(p3o), .port_three_oe(p3e),
		.dual_clock_mode, .ext_irq_zero_input(irq0), .ext_irq_five_fall(irq5),
		.analog_channel_onehot(onehot), .analog_enable);
	pio_board i_pio_board (.oe_zero(p0e), .out_one(p1o), .oe_one(p1e), .oe_two(p2e), .out_three(p3o),
		.oe_three(p3e), .ext_zero(e0), .ext_one(e1), .ext_two(e2), .ext_three(e3), .lvl_zero(p0i),
		.lvl_one(p1i), .lvl_two(p2i), .lvl_three(p3i));
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task bus(input logic w, input logic [7:0] i, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= pio_pkg::HTRANS_NONSEQ;
		haddr <= {22'h0, i, 2'h0};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= pio_pkg::HTRANS_IDLE;
		hwdata <= {24'h0, d};
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask
	task rchk(input string n, input logic [7:0] i, input logic [31:0] e);
		bus(1'b0, i, 8'h00);
		chk(n, rd, e);
	endtask
	task t_reset;
		rchk("p0 latch", pio_pkg::IDX_P0_LAT, 32'hFF);
		rchk("p1 latch", pio_pkg::IDX_P1_LAT, 32'h00);
		rchk("p1 dir", pio_pkg::IDX_P1_DIR, 32'h00);
		rchk("p2 latch", pio_pkg::IDX_P2_LAT, 32'h07);
		rchk("adc ctl", pio_pkg::IDX_ADC_CR1, 32'h10);
		chk("p3 oe", p3e, 8'h00);
		chk("no false fall", falls, 0);
	endtask
	task t_port_zero;
		bus(1'b1, pio_pkg::IDX_P0_LAT, 8'h5A);
		e0 <= 8'hC3;
		cyc(3);
		chk("p0 oe", p0e, 8'hA5);
		rchk("p0 pins", pio_pkg::IDX_P0_PIN, 32'h42);
		bus(1'b1, pio_pkg::IDX_P0_PIN, 8'h00);
		rchk("p0 latch", pio_pkg::IDX_P0_LAT, 32'h5A);
		rchk("unmapped", 8'h05, 32'h00);
		chk("unmapped resp", hresp, pio_pkg::HRESP_OKAY);
		chk("p0 out", p0o, 8'h00);
		chk("p2 out", p2o, 3'h0);
		bus(1'b1, pio_pkg::IDX_P0_LAT, 8'hFF);
		bus(1'b1, pio_pkg::IDX_EINT_CR, 8'h40);
		e0 <= 8'hFE;
		cyc(3);
		chk("irq0 on", irq0, 1'b0);
		bus(1'b1, pio_pkg::IDX_EINT_CR, 8'h00);
		cyc(1);
		chk("irq0 off", irq0, 1'b1);
	endtask
	task t_port_one;
		bus(1'b1, pio_pkg::IDX_P1_LAT, 8'hF0);
		e1 <= 8'h3C;
		cyc(3);
		chk("p1 out", p1o, 8'hF0);
		chk("p1 oe", p1e, 8'h00);
		rchk("p1 in", pio_pkg::IDX_P1_LAT, 32'h3C);
		bus(1'b1, pio_pkg::IDX_P1_DIR, 8'h0F);
		cyc(3);
		chk("p1 dir oe", p1e, 8'h0F);
		rchk("p1 mixed", pio_pkg::IDX_P1_LAT, 32'h30);
		bus(1'b1, pio_pkg::IDX_P1_LAT, rd[7:0] | 8'h01);
		cyc(1);
		chk("p1 rmw", p1o, 8'h31);
	endtask
	task t_port_two;
		f = falls;
		bus(1'b1, pio_pkg::IDX_P2_LAT, 8'hFE);
		cyc(1);
		chk("p2 oe", p2e, 3'h1);
		rchk("p2 latch", pio_pkg::IDX_P2_LAT, 32'h06);
		cyc(2);
		rchk("p2 pins", pio_pkg::IDX_P2_PIN, 32'h06);
		chk("p2 falls", falls - f, 1);
		bus(1'b1, pio_pkg::IDX_P2_LAT, 8'h00);
		dual_clock_mode <= 1'b1;
		cyc(2);
		chk("dual oe", p2e, 3'h1);
		dual_clock_mode <= 1'b0;
		cyc(2);
		chk("single oe", p2e, 3'h7);
	endtask
	task t_port_three;
		bus(1'b1, pio_pkg::IDX_P3_DIR, 8'hFF);
		bus(1'b1, pio_pkg::IDX_P3_LAT, 8'hAA);
		bus(1'b1, pio_pkg::IDX_ADC_CR1, 8'h03);
		cyc(1);
		chk("onehot", onehot, 8'h08);
		chk("p3 oe", p3e, 8'hF7);
		rchk("p3 latch", pio_pkg::IDX_P3_LAT, 32'hA2);
		e3 <= 8'hFF;
		bus(1'b1, pio_pkg::IDX_P3_DIR, 8'h00);
		cyc(3);
		rchk("p3 pins", pio_pkg::IDX_P3_LAT, 32'hF7);
		bus(1'b1, pio_pkg::IDX_ADC_CR1, 8'h10);
		cyc(1);
		chk("analog off", analog_enable, 1'b0);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		cyc(2);
		hresetn <= 1'b1;
		cyc(1);
		t_reset;
		t_port_zero;
		t_port_one;
		t_port_two;
		t_port_three;
		report_and_stop;
	end
	// Whole run needs some 90 cycles
	initial begin
		cyc(3000);
		bad_count++;
		report_and_stop;
	end
endmodule
